// File: hw/dual_sensor_alarm_monitor.v
// Two independent condition-monitoring alarms with register port and indicator line
// Operation
// [R1] Two independent alarms, each with threshold, count, source and mode.
// [R2] Static mode: threshold bit 15 set fires above, clear fires below.
// [R3] Threshold magnitude in bits 13..0, source format; bit 14 unused.
// [R4] Dynamic mode fires when change over N samples exceeds magnitude.
// [R5] Sample count in bits 7..0; zero and one both mean one sample.
// [R6] Configuration bits 15..12 pick alarm two source; 0000 disables.
// [R7] Configuration bits 11..8 pick alarm one source, same codes.
// [R8] Configuration bit 7 sets alarm two dynamic (1) or static (0).
// [R9] Configuration bit 6 sets alarm one dynamic (1) or static (0).
// [R10] Configuration bit 4 picks filtered data; bits 5 and 3 unused.
// [R11] Configuration bit 2 enables the hardware indicator output.
// [R12] Configuration bit 1 sets indicator active level high or low.
// [R13] Configuration bit 0 routes indicator to line two, else line one.
// [R14] Alarm conditions reported on diagnostic status bits 9 and 8.
// [R15] Alarm one is bit 8, alarm two bit 9; indicator active on either.
// [R16] Evaluate once per sample update; keep history covering sample count. A sample that coincides with a configuration write is not evaluated.
`timescale 1ns/1ps
`include "alarm_defines.vh"
module dual_sensor_alarm_monitor (
  input wire clk_i, // Internal sample clock, 250 MHz
  input wire nrst_i, // Asynchronous reset, active low
  input wire [6:0] reg_addr_i, // Register byte address
  input wire [15:0] reg_wdata_i, // Register write data
  input wire reg_wr_i, // Register write strobe
  input wire reg_rd_i, // Register read strobe
  output reg [15:0] reg_rdata_o, // Registered read data
  input wire sample_valid_i, // One-cycle pulse per sample update
  input wire [223:0] src_raw_i, // Unfiltered outputs, 14 bits per source code
  input wire [223:0] src_filt_i, // Filtered outputs, 14 bits per source code
  output reg [1:0] diagnostic_status_o, // Alarm flags, status bits 9:8
  output reg digital_line_one_o, // Indicator level on line one
  output reg digital_line_one_oe_o, // Line one driven by indicator
  output reg digital_line_two_o, // Indicator level on line two
  output reg digital_line_two_oe_o // Line two driven by indicator
);

  // Registers
  reg [15:0] thr_one_q;
  reg [15:0] thr_two_q;
  reg [7:0] cnt_one_q;
  reg [7:0] cnt_two_q;
  reg [15:0] cfg_q;

  // History pointers and evaluation pipeline
  reg [7:0] wp_q;
  reg [7:0] fill_one_q;
  reg [7:0] fill_two_q;
  reg eval_q;
  reg [13:0] cur_one_q;
  reg [13:0] cur_two_q;
  reg ok_one_q;
  reg ok_two_q;

  wire [3:0] code_one;
  wire [3:0] code_two;
  wire [13:0] smp_one;
  wire [13:0] smp_two;
  wire [7:0] n_one;
  wire [7:0] n_two;
  wire [13:0] old_one;
  wire [13:0] old_two;
  wire hit_one;
  wire hit_two;
  wire cfg_wr;

  // Pick one source value by code; filtered or unfiltered bank
  function [13:0] pick_source;
    input [3:0] code;
    input filt;
    input [223:0] raw;
    input [223:0] flt;
    begin
      pick_source = filt ? flt[code * 14 +: 14] : raw[code * 14 +: 14];
    end
  endfunction

  // Codes 0, 8 and above 12 select nothing, so the alarm stays quiet
  function code_valid;
    input [3:0] code;
    begin
      code_valid = (code != `SRC_DISABLE) && (code != `SRC_GAP) && (code <= `SRC_AUX);
    end
  endfunction

  // Zero and one both mean a one-sample period
  function [7:0] eff_count;
    input [7:0] cnt;
    begin
      eff_count = (cnt <= 8'h01) ? 8'h01 : cnt;
    end
  endfunction

  assign code_one = cfg_q[`CFG_SRC_ONE_MSB:`CFG_SRC_ONE_LSB]; // see [R7]
  assign code_two = cfg_q[`CFG_SRC_TWO_MSB:`CFG_SRC_TWO_LSB]; // see [R6]
  assign smp_one = pick_source(code_one, cfg_q[`CFG_FILT_BIT], src_raw_i, src_filt_i); // see [R10]
  assign smp_two = pick_source(code_two, cfg_q[`CFG_FILT_BIT], src_raw_i, src_filt_i); // see [R10]
  assign n_one = eff_count(cnt_one_q); // see [R5]
  assign n_two = eff_count(cnt_two_q); // see [R5]
  assign cfg_wr = reg_wr_i && (reg_addr_i == `ALM_CFG_ADDR);

  // Register writes; unused bits are dropped so they read back as zero
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      thr_one_q <= `ALM_THR_RESET;
      thr_two_q <= `ALM_THR_RESET;
      cnt_one_q <= `ALM_CNT_RESET;
      cnt_two_q <= `ALM_CNT_RESET;
      cfg_q <= `ALM_CFG_RESET;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `ALM_ONE_THR_ADDR: thr_one_q <= {reg_wdata_i[15], 1'b0, reg_wdata_i[13:0]}; // see [R3]
        `ALM_TWO_THR_ADDR: thr_two_q <= {reg_wdata_i[15], 1'b0, reg_wdata_i[13:0]}; // see [R3]
        `ALM_ONE_CNT_ADDR: cnt_one_q <= reg_wdata_i[7:0]; // see [R5]
        `ALM_TWO_CNT_ADDR: cnt_two_q <= reg_wdata_i[7:0]; // see [R5]
        `ALM_CFG_ADDR: cfg_q <= reg_wdata_i & `CFG_WRITE_MASK; // see [R10]
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // Register reads; unmapped offsets return zero
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      reg_rdata_o <= 16'h0000;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `ALM_ONE_THR_ADDR: reg_rdata_o <= thr_one_q;
        `ALM_TWO_THR_ADDR: reg_rdata_o <= thr_two_q;
        `ALM_ONE_CNT_ADDR: reg_rdata_o <= {8'h00, cnt_one_q};
        `ALM_TWO_CNT_ADDR: reg_rdata_o <= {8'h00, cnt_two_q};
        `ALM_CFG_ADDR: reg_rdata_o <= cfg_q;
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  // Shared write pointer; fill counts restart on a configuration write
  // because older history belongs to another source or filter setting
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wp_q <= 8'h00;
      fill_one_q <= 8'h00;
      fill_two_q <= 8'h00;
      eval_q <= 1'b0;
      cur_one_q <= 14'h0000;
      cur_two_q <= 14'h0000;
      ok_one_q <= 1'b0;
      ok_two_q <= 1'b0;
    end
    else
    begin
      // A sample that meets a configuration write is dropped, so no stale evaluation follows
      eval_q <= sample_valid_i && !cfg_wr; // see [R16]
      if (cfg_wr)
      begin
        fill_one_q <= 8'h00;
        fill_two_q <= 8'h00;
      end
      else if (sample_valid_i)
      begin
        wp_q <= wp_q + 8'h01;
        cur_one_q <= smp_one;
        cur_two_q <= smp_two;
        ok_one_q <= fill_one_q >= n_one; // see [R16]
        ok_two_q <= fill_two_q >= n_two; // see [R16]
        if (fill_one_q != `HIST_FULL)
        begin
          fill_one_q <= fill_one_q + 8'h01;
        end
        if (fill_two_q != `HIST_FULL)
        begin
          fill_two_q <= fill_two_q + 8'h01;
        end
      end
    end
  end

  // Separate histories keep the two channels' samples apart; the write pointer is shared
  alarm_history_mem hist_one (
    .clk_i(clk_i),
    .wr_en_i(sample_valid_i),
    .wr_addr_i(wp_q),
    .wr_data_i(smp_one),
    .rd_en_i(sample_valid_i),
    .rd_addr_i(wp_q - n_one), // see [R16]
    .rd_data_o(old_one)
  );

  alarm_history_mem hist_two (
    .clk_i(clk_i),
    .wr_en_i(sample_valid_i),
    .wr_addr_i(wp_q),
    .wr_data_i(smp_two),
    .rd_en_i(sample_valid_i),
    .rd_addr_i(wp_q - n_two), // see [R16]
    .rd_data_o(old_two)
  );

  // One comparator per channel; see [R1]
  alarm_compare cmp_one (
    .enabled_i(code_valid(code_one)),
    .dynamic_i(cfg_q[`CFG_DYN_ONE_BIT]), // see [R9]
    .thr_i(thr_one_q),
    .cur_i(cur_one_q),
    .old_i(old_one),
    .hist_ok_i(ok_one_q),
    .hit_o(hit_one)
  );

  alarm_compare cmp_two (
    .enabled_i(code_valid(code_two)),
    .dynamic_i(cfg_q[`CFG_DYN_TWO_BIT]), // see [R8]
    .thr_i(thr_two_q),
    .cur_i(cur_two_q),
    .old_i(old_two),
    .hist_ok_i(ok_two_q),
    .hit_o(hit_two)
  );

  // Flags follow the latest evaluation; a disabled source clears its flag
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      diagnostic_status_o <= 2'b00;
    end
    else if (eval_q)
    begin
      diagnostic_status_o <= {hit_two, hit_one}; // see [R14] see [R15]
    end
  end

  // Indicator follows the flag register, so it lags the flags by one cycle
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      digital_line_one_o <= 1'b0;
      digital_line_one_oe_o <= 1'b0;
      digital_line_two_o <= 1'b0;
      digital_line_two_oe_o <= 1'b0;
    end
    else
    begin
      digital_line_one_oe_o <= cfg_q[`CFG_IND_EN_BIT] && !cfg_q[`CFG_IND_SEL_BIT]; // see [R11] see [R13]
      digital_line_two_oe_o <= cfg_q[`CFG_IND_EN_BIT] && cfg_q[`CFG_IND_SEL_BIT]; // see [R11] see [R13]
      digital_line_one_o <= (|diagnostic_status_o) ~^ cfg_q[`CFG_IND_POL_BIT]; // see [R12] see [R15]
      digital_line_two_o <= (|diagnostic_status_o) ~^ cfg_q[`CFG_IND_POL_BIT]; // see [R12] see [R15]
    end
  end

endmodule

// File: hw/alarm_defines.vh
// Register offsets, field positions and reset values of the dual alarm monitor
`ifndef ALARM_DEFINES_VH
`define ALARM_DEFINES_VH

// Register byte offsets
`define ALM_ONE_THR_ADDR 7'h44
`define ALM_TWO_THR_ADDR 7'h46
`define ALM_ONE_CNT_ADDR 7'h48
`define ALM_TWO_CNT_ADDR 7'h4a
`define ALM_CFG_ADDR 7'h4c

// Reset values
`define ALM_THR_RESET 16'h0000
`define ALM_CNT_RESET 8'h00
`define ALM_CFG_RESET 16'h0000

// Threshold fields
`define THR_POL_BIT 15
`define THR_MAG_MSB 13
`define THR_WIDTH 14

// Configuration fields
`define CFG_SRC_TWO_MSB 15
`define CFG_SRC_TWO_LSB 12
`define CFG_SRC_ONE_MSB 11
`define CFG_SRC_ONE_LSB 8
`define CFG_DYN_TWO_BIT 7
`define CFG_DYN_ONE_BIT 6
`define CFG_FILT_BIT 4
`define CFG_IND_EN_BIT 2
`define CFG_IND_POL_BIT 1
`define CFG_IND_SEL_BIT 0
`define CFG_WRITE_MASK 16'hffd7

// Source codes
`define SRC_DISABLE 4'h0
`define SRC_SUPPLY 4'h1
`define SRC_AUX 4'hc
`define SRC_GAP 4'h8
`define SRC_SLOTS 16

// History depth
`define HIST_AW 8
`define HIST_FULL 8'hff

`endif

// File: hw/alarm_history_mem.v
// Sample history memory for one alarm channel, registered read port
`timescale 1ns/1ps
module alarm_history_mem (
  input wire clk_i, // System clock
  input wire wr_en_i, // Write strobe
  input wire [7:0] wr_addr_i, // Write address
  input wire [13:0] wr_data_i, // Sample to store
  input wire rd_en_i, // Read strobe
  input wire [7:0] rd_addr_i, // Read address
  output reg [13:0] rd_data_o // Registered read data
);

  reg [13:0] mem [0:255];

  // No reset on the array; validity is tracked by the caller's fill count
  always @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
    if (rd_en_i)
    begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

// File: hw/alarm_compare.v
// Static and dynamic trigger decision for one alarm channel
`timescale 1ns/1ps
`include "alarm_defines.vh"
module alarm_compare (
  input wire enabled_i, // Source code selects a real output
  input wire dynamic_i, // High for rate-of-change mode
  input wire [15:0] thr_i, // Threshold register
  input wire [13:0] cur_i, // Newest sample
  input wire [13:0] old_i, // Sample N updates earlier
  input wire hist_ok_i, // History covers N samples
  output reg hit_o // Trigger condition
);

  reg signed [14:0] diff;
  reg [14:0] mag;
  reg signed [13:0] thr_s;

  // Static: signed compare with polarity; dynamic: |cur-old| against magnitude
  always @*
  begin
    diff = $signed({cur_i[13], cur_i}) - $signed({old_i[13], old_i});
    mag = diff[14] ? (15'h0000 - diff) : diff;
    thr_s = thr_i[13:0];
    hit_o = 1'b0;
    if (enabled_i)
    begin
      if (dynamic_i)
      begin
        hit_o = hist_ok_i && (mag > {1'b0, thr_i[13:0]}); // see [R4]
      end
      else if (thr_i[`THR_POL_BIT])
      begin
        hit_o = $signed(cur_i) > thr_s; // see [R2]
      end
      else
      begin
        hit_o = $signed(cur_i) < thr_s; // see [R2]
      end
    end
  end

endmodule

// File: sim/indicator_host.sv
// Host-side view of the two indicator lines
`timescale 1ns/1ps
module indicator_host (
  input wire [3:0] line_i, // {oe two, level two, oe one, level one}
  output wire [1:0] seen_o // Level the host sees on each line
);
  reg [1:0] last_q = 2'b00;

  // Remember the last driven level of each line
  always @*
  begin
    if (line_i[1])
      last_q[0] = line_i[0];
    if (line_i[3])
      last_q[1] = line_i[2];
  end

  // Released line shows the inverse, so a stale level never passes
  assign seen_o[0] = line_i[1] ? line_i[0] : ~last_q[0];
  assign seen_o[1] = line_i[3] ? line_i[2] : ~last_q[1];
endmodule

// File: sim/dual_sensor_alarm_monitor_sva.sv
// Port checks for the dual alarm monitor
`timescale 1ns/1ps
module dual_sensor_alarm_monitor_sva (
  input wire clk_i, // Sample clock
  input wire nrst_i, // Async reset, active low
  input wire [6:0] reg_addr_i, // Register address
  input wire [15:0] reg_wdata_i, // Write data
  input wire reg_wr_i, // Write strobe
  input wire reg_rd_i, // Read strobe
  input wire [15:0] reg_rdata_o, // Read data
  input wire sample_valid_i, // Sample pulse
  input wire [1:0] diagnostic_status_o, // Alarm flags
  input wire digital_line_one_o, // Line one level
  input wire digital_line_one_oe_o, // Line one enable
  input wire digital_line_two_oe_o // Line two enable
);
  reg [15:0] cfg_q;
  reg [2:0] quiet_q;

  // Shadow configuration; quiet counts edges since a write, so checks skip settling
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg_q <= 16'h0000;
      quiet_q <= 3'h0;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == 7'h4c)
        cfg_q <= reg_wdata_i & 16'hffd7;
      if (reg_wr_i)
        quiet_q <= 3'h0;
      else if (quiet_q != 3'h7)
        quiet_q <= quiet_q + 3'h1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  oe_route_a: assert property (quiet_q > 3'h2 |->
    digital_line_one_oe_o == (cfg_q[2] & ~cfg_q[0]) && digital_line_two_oe_o == (cfg_q[2] & cfg_q[0]))
    else $error("indicator enable wrong");
  line_level_a: assert property (quiet_q > 3'h3 |->
    digital_line_one_o == ((|$past(diagnostic_status_o)) ~^ cfg_q[1])) else $error("indicator level wrong");
  flag_timing_a: assert property ($changed(diagnostic_status_o) |-> $past(sample_valid_i, 2))
    else $error("flags moved without sample");
  off_one_a: assert property ($past(sample_valid_i, 2) && quiet_q > 3'h4 && cfg_q[11:8] == 4'h0
    |-> !diagnostic_status_o[0]) else $error("disabled alarm one flagged");
  off_two_a: assert property ($past(sample_valid_i, 2) && quiet_q > 3'h4 && cfg_q[15:12] > 4'hc
    |-> !diagnostic_status_o[1]) else $error("invalid alarm two flagged");
  cfg_read_a: assert property (reg_rd_i && reg_addr_i == 7'h4c |=> reg_rdata_o == $past(cfg_q))
    else $error("configuration read wrong");
  thr_read_a: assert property (reg_rd_i && reg_addr_i[6:2] == 5'h11 |=> !reg_rdata_o[14])
    else $error("threshold bit 14 set");
  cnt_read_a: assert property (reg_rd_i && reg_addr_i[6:2] == 5'h12 |=> reg_rdata_o[15:8] == 8'h00)
    else $error("count upper byte set");
  hole_read_a: assert property (reg_rd_i && (reg_addr_i < 7'h44 || reg_addr_i > 7'h4c) |=>
    reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
endmodule

bind dual_sensor_alarm_monitor dual_sensor_alarm_monitor_sva checker_i (.clk_i, .nrst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sample_valid_i, .diagnostic_status_o,
  .digital_line_one_o, .digital_line_one_oe_o, .digital_line_two_oe_o);

// File: sim/test_dual_sensor_alarm_monitor.sv
// Self-checking bench for the dual alarm monitor
`timescale 1ns/1ps
module test_dual_sensor_alarm_monitor;
  reg clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg [6:0] reg_addr_i = 7'h00;
  reg [15:0] reg_wdata_i = 16'h0000;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg sample_valid_i = 1'b0;
  reg [223:0] src_raw_i = 224'h0;
  reg [223:0] src_filt_i = 224'h0;
  wire [15:0] reg_rdata_o;
  wire [1:0] diagnostic_status_o;
  wire [3:0] line_w;
  wire [1:0] seen_w;
  integer failures = 0;
  integer checked = 0;
  integer seed = 32'h2cde;
  integer thr [0:1];
  integer cnt [0:1];
  integer hist [0:1][0:7];
  integer cfg, code, ch, k, s, i, n, v, t;
  reg [223:0] w, r, f;
  reg [1:0] flags;

  always #2 clk_i = ~clk_i;

  dual_sensor_alarm_monitor DUT (.clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .sample_valid_i, .src_raw_i, .src_filt_i, .diagnostic_status_o,
    .digital_line_one_o(line_w[0]), .digital_line_one_oe_o(line_w[1]),
    .digital_line_two_o(line_w[2]), .digital_line_two_oe_o(line_w[3]));

  indicator_host HOST (.line_i(line_w), .seen_o(seen_w));

  task finish_test;
  begin
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  task chk(input [15:0] got, input [15:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      $display("ERROR %0t got %h exp %h", $time, got, exp);
      failures = failures + 1;
    end
  end
  endtask

  task wr(input [6:0] a, input [15:0] d);
  begin
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  end
  endtask

  task rd(input [6:0] a, input [15:0] e);
  begin
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  end
  endtask

  // Model both alarms on fresh random sources, then pulse one sample
  task sample;
  begin
    for (i = 0; i < 7; i = i + 1)
    begin
      r[i*32+:32] = $random(seed);
      f[i*32+:32] = $random(seed);
    end
    w = cfg[4] ? f : r;
    for (ch = 0; ch < 2; ch = ch + 1)
    begin
      code = (cfg >> (8 + 4 * ch)) & 15;
      v = (w >> (code * 14)) & 16383;
      v = v > 8191 ? v - 16384 : v;
      t = thr[ch] & 16383;
      n = (cnt[ch] & 255) < 2 ? 1 : cnt[ch] & 255;
      flags[ch] = 1'b0;
      if (code != 0 && code != 8 && code < 13)
        if (cfg[6 + ch])
          flags[ch] = s >= n && (v - hist[ch][s-n] > t || hist[ch][s-n] - v > t);
        else
          flags[ch] = thr[ch][15] ? v > t - (t > 8191 ? 16384 : 0) : v < t - (t > 8191 ? 16384 : 0);
      hist[ch][s] = v;
    end
    s = s + 1;
    @(posedge clk_i);
    src_raw_i <= r;
    src_filt_i <= f;
    sample_valid_i <= 1'b1;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk({14'h0, diagnostic_status_o}, {14'h0, flags});
    @(posedge clk_i);
    #1 chk({line_w[3], line_w[1], seen_w[cfg[0]] & cfg[2]},
      {cfg[2] & cfg[0], cfg[2] & ~cfg[0], cfg[2] & ((|flags) ~^ cfg[1])});
  end
  endtask

  // Reset values, then one configuration per alarm one source code
  initial
  begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (k = 0; k < 6; k = k + 1)
      rd(7'h44 + {k[5:0], 1'b0}, 16'h0000);
    for (k = 0; k < 16; k = k + 1)
    begin
      thr[0] = $random(seed);
      thr[1] = $random(seed);
      cnt[0] = $random(seed) & 16'hff07;
      cnt[1] = $random(seed) & 16'hff07;
      cfg = ($random(seed) & 16'hf0ff) | (k << 8);
      wr(7'h44, thr[0][15:0]);
      wr(7'h46, thr[1][15:0]);
      wr(7'h48, cnt[0][15:0]);
      wr(7'h4a, cnt[1][15:0]);
      wr(7'h4c, cfg[15:0]);
      rd(7'h44, thr[0][15:0] & 16'hbfff);
      rd(7'h46, thr[1][15:0] & 16'hbfff);
      rd(7'h48, cnt[0][15:0] & 16'h00ff);
      rd(7'h4a, cnt[1][15:0] & 16'h00ff);
      rd(7'h4c, cfg[15:0] & 16'hffd7);
      s = 0;
      repeat (6) sample;
    end
    finish_test;
  end

  // About 810 cycles expected; allow a wide margin
  initial
  begin
    #40000;
    failures = failures + 1;
    finish_test;
  end
endmodule
